//--- design/bpt_core_timing.sv
// branch prediction, penalty and issue timing control for the core
// ==============================================================
// What this block does
// - predicts direct branch, branch_with_link and compressed direct branch.
// - instructions writing the program counter predict not taken, pay penalty when taken.
// - predictable branches enter the buffer only on first taken outcome.
// - buffered branches predict from recorded history of earlier outcomes.
// - correctly predicted buffered branch costs zero extra issue cycles.
// - misprediction costs four cycles wide state, five compressed state.
// - misprediction: buffered wrong either way, or unbuffered yet taken.
// - mispredicted issue latency equals predicted latency plus penalty.
// - addressing modes and base writeback add no latency cycles.
// - consumers wait for producer result latency from its issue cycle.
// - multiplies wait prior multiply resource latency regardless of data.
// - long block loads, faults, pending loads, walks, slow bus delay irq.
// - interrupt latency counted in core cycles from request to vector.
`timescale 1ns/1ns
module bpt_core_timing #(
    parameter int BTB_ENTRIES = 64,
    parameter int BTB_IDX_W = 6
) (
    input logic i_mclk,
    input logic i_rst,
    input logic i_cand_vld,
    input logic [31:0] i_cand_pc,
    input bpt_pkg::bpt_kind_e i_cand_kind,
    input logic i_cand_dest_vld,
    input logic [bpt_pkg::REG_W-1:0] i_cand_dest,
    input logic i_cand_wb_vld,
    input logic [bpt_pkg::REG_W-1:0] i_cand_wb,
    input logic [bpt_pkg::REG_NUM-1:0] i_cand_src_mask,
    input logic [bpt_pkg::LAT_W-1:0] i_cand_res_lat,
    input logic [bpt_pkg::LAT_W-1:0] i_cand_rsrc_lat,
    input logic i_res_vld,
    input logic [31:0] i_res_pc,
    input bpt_pkg::bpt_kind_e i_res_kind,
    input logic i_res_cmp,
    input logic i_res_taken,
    input logic [31:0] i_res_target,
    input logic i_res_hit,
    input logic i_res_pred_taken,
    input logic i_irq,
    input logic i_fast_interrupt_request,
    input logic i_vector_exec,
    input logic i_blk_load16,
    input logic i_fault,
    input logic i_load_wait,
    input logic i_walk_busy,
    input logic i_ratio_high,
    output logic o_issue,
    output logic o_pred_hit,
    output logic o_pred_taken,
    output logic [31:0] o_pred_target,
    output logic o_mispredict,
    output logic [31:0] o_redirect_target,
    output logic o_pen_busy,
    output logic [bpt_pkg::ILAT_W-1:0] o_irq_lat,
    output logic o_irq_lat_vld,
    output logic o_irq_fast,
    output logic o_irq_slow
);
    localparam int LAT_W = bpt_pkg::LAT_W;

    // ==========================================================
    // declarations
    logic look_hit, look_taken;
    logic [31:0] look_target;
    logic cand_pred, res_pred, res_upd, mis_now;
    logic [bpt_pkg::PEN_W-1:0] pen_reg;
    logic [LAT_W-1:0] mul_reg;
    logic [LAT_W-1:0] cnt_reg [bpt_pkg::REG_NUM];
    logic [bpt_pkg::REG_NUM-1:0] busy_vec;
    logic dep_haz, mul_haz, pen_haz, go_next;
    logic [LAT_W-1:0] lat_eff, rsrc_eff;

    // ==========================================================
    // prediction lookup
    // only the three direct branch forms are predictable
    assign cand_pred = i_cand_kind == bpt_pkg::KIND_BR
        || i_cand_kind == bpt_pkg::KIND_BR_LINK
        || i_cand_kind == bpt_pkg::KIND_BR_CMP;
    assign res_pred = i_res_kind == bpt_pkg::KIND_BR
        || i_res_kind == bpt_pkg::KIND_BR_LINK
        || i_res_kind == bpt_pkg::KIND_BR_CMP;
    assign res_upd = i_res_vld && res_pred;

    bpt_btb #(
        .ENTRIES(BTB_ENTRIES),
        .IDX_W(BTB_IDX_W)
    ) u_btb (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_look_pc(i_cand_pc),
        .o_look_hit(look_hit),
        .o_look_taken(look_taken),
        .o_look_target(look_target),
        .i_upd_vld(res_upd),
        .i_upd_pc(i_res_pc),
        .i_upd_taken(i_res_taken),
        .i_upd_target(i_res_target)
    );

    // misprediction classes; pc writes are always predicted not taken
    always_comb begin
        mis_now = 1'b0;
        if (i_res_vld && res_pred) begin
            mis_now = (i_res_hit && !i_res_pred_taken && i_res_taken)
                || (!i_res_hit && i_res_taken)
                || (i_res_hit && i_res_pred_taken && !i_res_taken);
        end else if (i_res_vld && i_res_kind == bpt_pkg::KIND_PC_WRITE) begin
            mis_now = i_res_taken;
        end
    end

    // ==========================================================
    // issue hazards
    // a source is busy while its counter says more than one cycle left
    generate
        for (genvar r = 0; r < bpt_pkg::REG_NUM; r++) begin : g_sb
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    cnt_reg[r] <= bpt_pkg::LAT_ZERO;
                end else if (go_next && ((i_cand_dest_vld
                    && i_cand_dest == r) || (i_cand_wb_vld
                    && i_cand_wb == r))) begin
                    cnt_reg[r] <= lat_eff;
                end else if (cnt_reg[r] != bpt_pkg::LAT_ZERO) begin
                    cnt_reg[r] <= cnt_reg[r] - bpt_pkg::LAT_ONE;
                end
            end
            assign busy_vec[r] = cnt_reg[r] > bpt_pkg::LAT_ONE;
        end
    endgenerate

    // zero latency codes are treated as one cycle
    assign lat_eff = (i_cand_res_lat == bpt_pkg::LAT_ZERO)
        ? bpt_pkg::LAT_ONE : i_cand_res_lat;
    assign rsrc_eff = (i_cand_rsrc_lat == bpt_pkg::LAT_ZERO)
        ? bpt_pkg::LAT_ONE : i_cand_rsrc_lat;

    assign dep_haz = |(i_cand_src_mask & busy_vec);
    assign mul_haz = i_cand_kind == bpt_pkg::KIND_MUL
        && mul_reg > bpt_pkg::LAT_ONE;
    assign pen_haz = mis_now || pen_reg > bpt_pkg::PEN_ONE;
    assign go_next = i_cand_vld && !dep_haz && !mul_haz && !pen_haz;

    // multiply resource counter, loaded by each multiply issue
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mul_reg <= bpt_pkg::LAT_ZERO;
        end else if (go_next && i_cand_kind == bpt_pkg::KIND_MUL) begin
            mul_reg <= rsrc_eff;
        end else if (mul_reg != bpt_pkg::LAT_ZERO) begin
            mul_reg <= mul_reg - bpt_pkg::LAT_ONE;
        end
    end

    // penalty counter, loaded only by a misprediction
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pen_reg <= bpt_pkg::PEN_ZERO;
        end else if (mis_now) begin
            pen_reg <= i_res_cmp ? bpt_pkg::PEN_CMP
                : bpt_pkg::PEN_WIDE;
        end else if (pen_reg != bpt_pkg::PEN_ZERO) begin
            pen_reg <= pen_reg - bpt_pkg::PEN_ONE;
        end
    end

    // ==========================================================
    // registered outputs
    // issue pulse and prediction for the instruction that issues
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_issue <= 1'b0;
            o_pred_hit <= 1'b0;
            o_pred_taken <= 1'b0;
            o_pred_target <= '0;
        end else begin
            o_issue <= go_next;
            if (go_next) begin
                o_pred_hit <= cand_pred && look_hit;
                o_pred_taken <= cand_pred && look_taken;
                o_pred_target <= look_target;
            end
        end
    end

    // misprediction flag, redirect address and penalty window
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_mispredict <= 1'b0;
            o_redirect_target <= '0;
            o_pen_busy <= 1'b0;
        end else begin
            o_mispredict <= mis_now;
            if (mis_now) begin
                o_redirect_target <= i_res_taken ? i_res_target
                    : i_res_pc + (i_res_cmp ? 32'h2 : 32'h4);
            end
            o_pen_busy <= pen_haz;
        end
    end

    // ==========================================================
    // interrupt latency
    bpt_irq_lat u_irq (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_irq(i_irq),
        .i_fast_interrupt_request(i_fast_interrupt_request),
        .i_vector_exec(i_vector_exec),
        .i_slow_cause(i_blk_load16 | i_fault | i_load_wait
            | i_walk_busy | i_ratio_high),
        .o_lat(o_irq_lat),
        .o_lat_vld(o_irq_lat_vld),
        .o_fast(o_irq_fast),
        .o_slow(o_irq_slow)
    );

    // ==========================================================
    // checks
    logic [LAT_W-1:0] last_lat_reg, last_rsrc_reg, since_mul_reg;
    logic [bpt_pkg::REG_W-1:0] last_dest_reg;
    logic last_dest_vld_reg, seen_mul_reg, iss_mul_reg;

    // helper state: last producer and distance since last multiply
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            last_lat_reg <= '0;
            last_dest_reg <= '0;
            last_dest_vld_reg <= 1'b0;
            last_rsrc_reg <= '0;
            since_mul_reg <= '0;
            seen_mul_reg <= 1'b0;
            iss_mul_reg <= 1'b0;
        end else begin
            iss_mul_reg <= go_next && i_cand_kind == bpt_pkg::KIND_MUL;
            if (go_next) begin
                last_lat_reg <= lat_eff;
                last_dest_reg <= i_cand_dest;
                last_dest_vld_reg <= i_cand_dest_vld;
            end
            if (o_issue && iss_mul_reg) begin
                since_mul_reg <= bpt_pkg::LAT_ONE;
                last_rsrc_reg <= mul_reg;
                seen_mul_reg <= 1'b1;
            end else if (since_mul_reg != 4'hF) begin
                since_mul_reg <= since_mul_reg + bpt_pkg::LAT_ONE;
            end
        end
    end

    sequence s_mis_wide;
        mis_now && !i_res_cmp;
    endsequence
    sequence s_mis_cmp;
        mis_now && i_res_cmp;
    endsequence

    property p_pen_wide;
        @(posedge i_mclk) disable iff (i_rst)
        s_mis_wide |=> !o_issue [*4];
    endproperty
    a_pen_wide: assert property (p_pen_wide)
        else $error("issue inside four cycle penalty");

    property p_pen_cmp;
        @(posedge i_mclk) disable iff (i_rst)
        s_mis_cmp |=> !o_issue [*5];
    endproperty
    a_pen_cmp: assert property (p_pen_cmp)
        else $error("issue inside five cycle penalty");

    property p_pen_end;
        @(posedge i_mclk) disable iff (i_rst)
        (s_mis_wide ##4 (i_cand_vld && !dep_haz && !mul_haz
            && !mis_now)) |=> o_issue;
    endproperty
    a_pen_end: assert property (p_pen_end)
        else $error("issue held past the penalty");

    property p_zero_pen;
        @(posedge i_mclk) disable iff (i_rst)
        (i_res_vld && res_pred && i_res_hit
            && i_res_pred_taken == i_res_taken)
            |=> !o_mispredict && (pen_reg == bpt_pkg::PEN_ZERO
            || $past(pen_reg) != bpt_pkg::PEN_ZERO);
    endproperty
    a_zero_pen: assert property (p_zero_pen)
        else $error("penalty on a correct prediction");

    property p_miss_taken;
        @(posedge i_mclk) disable iff (i_rst)
        (i_res_vld && res_pred && !i_res_hit && i_res_taken)
            |=> o_mispredict && o_redirect_target == $past(i_res_target);
    endproperty
    a_miss_taken: assert property (p_miss_taken)
        else $error("unbuffered taken branch not flagged");

    property p_pcw_nt;
        @(posedge i_mclk) disable iff (i_rst)
        (go_next && i_cand_kind == bpt_pkg::KIND_PC_WRITE)
            |=> o_issue && !o_pred_hit && !o_pred_taken;
    endproperty
    a_pcw_nt: assert property (p_pcw_nt)
        else $error("pc write predicted taken");

    property p_dep;
        @(posedge i_mclk) disable iff (i_rst)
        (o_issue && last_dest_vld_reg && last_lat_reg > 4'h1
            && i_cand_vld && i_cand_src_mask[last_dest_reg])
            |=> !o_issue;
    endproperty
    a_dep: assert property (p_dep)
        else $error("consumer issued before result latency");

    property p_mul;
        @(posedge i_mclk) disable iff (i_rst)
        (o_issue && iss_mul_reg && seen_mul_reg)
            |-> since_mul_reg >= last_rsrc_reg;
    endproperty
    a_mul: assert property (p_mul)
        else $error("multiply issued inside resource latency");
endmodule

//--- design/bpt_pkg.sv
// shared constants and types for branch prediction and issue timing
package bpt_pkg;
    // ==========================================================
    // register scoreboard and latency fields
    localparam int REG_NUM = 16;
    localparam int REG_W = 4;
    localparam int LAT_W = 4;
    localparam logic [LAT_W-1:0] LAT_ONE = 4'h1;
    localparam logic [LAT_W-1:0] LAT_ZERO = 4'h0;

    // ==========================================================
    // instruction classes seen by the issue stage
    typedef enum logic [2:0] {
        KIND_OTHER,
        KIND_BR,
        KIND_BR_LINK,
        KIND_BR_CMP,
        KIND_PC_WRITE,
        KIND_MUL
    } bpt_kind_e;

    // ==========================================================
    // misprediction penalty in core cycles per instruction state
    localparam int PEN_W = 3;
    localparam logic [PEN_W-1:0] PEN_WIDE = 3'h4;
    localparam logic [PEN_W-1:0] PEN_CMP = 3'h5;
    localparam logic [PEN_W-1:0] PEN_ONE = 3'h1;
    localparam logic [PEN_W-1:0] PEN_ZERO = 3'h0;

    // ==========================================================
    // target buffer history counter
    localparam int CTR_W = 2;
    localparam logic [CTR_W-1:0] CTR_ALLOC = 2'h2;
    localparam logic [CTR_W-1:0] CTR_MAX = 2'h3;
    localparam logic [CTR_W-1:0] CTR_MIN = 2'h0;

    // ==========================================================
    // interrupt latency measure
    localparam int ILAT_W = 16;
    localparam logic [ILAT_W-1:0] ILAT_SYNC = 16'h0002;
    localparam logic [ILAT_W-1:0] ILAT_MAX = 16'hFFFF;
endpackage

//--- design/bpt_btb.sv
// direct mapped branch target buffer with two bit history
`timescale 1ns/1ns
module bpt_btb #(
    parameter int ENTRIES = 64,
    parameter int IDX_W = 6
) (
    input logic i_mclk,
    input logic i_rst,
    input logic [31:0] i_look_pc,
    output logic o_look_hit,
    output logic o_look_taken,
    output logic [31:0] o_look_target,
    input logic i_upd_vld,
    input logic [31:0] i_upd_pc,
    input logic i_upd_taken,
    input logic [31:0] i_upd_target
);
    localparam int TAG_W = 31 - IDX_W;

    logic [ENTRIES-1:0] valid_reg;
    logic [TAG_W-1:0] tag_mem [ENTRIES];
    logic [31:0] tgt_mem [ENTRIES];
    logic [bpt_pkg::CTR_W-1:0] ctr_mem [ENTRIES];
    logic [IDX_W-1:0] look_idx;
    logic [IDX_W-1:0] upd_idx;
    logic upd_hit;
    logic [bpt_pkg::CTR_W-1:0] ctr_cur;

    // halfword aligned index, remaining upper bits form the tag
    assign look_idx = i_look_pc[IDX_W:1];
    assign upd_idx = i_upd_pc[IDX_W:1];
    assign o_look_hit = valid_reg[look_idx]
        && tag_mem[look_idx] == i_look_pc[31:IDX_W+1];
    assign o_look_taken = o_look_hit
        && ctr_mem[look_idx] >= bpt_pkg::CTR_ALLOC;
    assign o_look_target = tgt_mem[look_idx];
    assign upd_hit = valid_reg[upd_idx]
        && tag_mem[upd_idx] == i_upd_pc[31:IDX_W+1];
    assign ctr_cur = ctr_mem[upd_idx];

    // entry valid bits, set only by a first taken outcome
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            valid_reg <= '0;
        end else if (i_upd_vld && !upd_hit && i_upd_taken) begin
            valid_reg[upd_idx] <= 1'b1;
        end
    end

    // allocation overwrites the slot; hits train the history
    always_ff @(posedge i_mclk) begin
        if (i_upd_vld && !upd_hit && i_upd_taken) begin
            tag_mem[upd_idx] <= i_upd_pc[31:IDX_W+1];
            tgt_mem[upd_idx] <= i_upd_target;
            ctr_mem[upd_idx] <= bpt_pkg::CTR_ALLOC;
        end else if (i_upd_vld && upd_hit) begin
            if (i_upd_taken && ctr_cur != bpt_pkg::CTR_MAX) begin
                ctr_mem[upd_idx] <= ctr_cur + 2'h1;
            end else if (!i_upd_taken && ctr_cur != bpt_pkg::CTR_MIN) begin
                ctr_mem[upd_idx] <= ctr_cur - 2'h1;
            end
            if (i_upd_taken) begin
                tgt_mem[upd_idx] <= i_upd_target;
            end
        end
    end
endmodule

//--- design/bpt_irq_lat.sv
// interrupt request synchroniser and latency counter
`timescale 1ns/1ns
module bpt_irq_lat (
    input logic i_mclk,
    input logic i_rst,
    input logic i_irq,
    input logic i_fast_interrupt_request,
    input logic i_vector_exec,
    input logic i_slow_cause,
    output logic [bpt_pkg::ILAT_W-1:0] o_lat,
    output logic o_lat_vld,
    output logic o_fast,
    output logic o_slow
);
    logic [1:0] irq_s1_reg, irq_s2_reg, irq_s3_reg;
    logic wait_reg, fast_reg, slow_reg;
    logic [bpt_pkg::ILAT_W-1:0] cnt_reg;
    logic rise_irq, rise_fast;

    // two stage synchronisers plus an edge history stage
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_s1_reg <= 2'h0;
            irq_s2_reg <= 2'h0;
            irq_s3_reg <= 2'h0;
        end else begin
            irq_s1_reg <= {i_fast_interrupt_request, i_irq};
            irq_s2_reg <= irq_s1_reg;
            irq_s3_reg <= irq_s2_reg;
        end
    end

    assign rise_irq = irq_s2_reg[0] && !irq_s3_reg[0];
    assign rise_fast = irq_s2_reg[1] && !irq_s3_reg[1];

    // count core cycles from request until the vector runs
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wait_reg <= 1'b0;
            cnt_reg <= '0;
            fast_reg <= 1'b0;
            slow_reg <= 1'b0;
        end else if (!wait_reg && (rise_irq || rise_fast)) begin
            wait_reg <= 1'b1;
            cnt_reg <= bpt_pkg::ILAT_SYNC;
            fast_reg <= rise_fast;
            slow_reg <= i_slow_cause;
        end else if (wait_reg) begin
            if (i_vector_exec) begin
                wait_reg <= 1'b0;
            end
            if (cnt_reg != bpt_pkg::ILAT_MAX) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
            slow_reg <= slow_reg | i_slow_cause;
        end
    end

    // report the count when the vector instruction executes
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_lat <= '0;
            o_lat_vld <= 1'b0;
            o_fast <= 1'b0;
            o_slow <= 1'b0;
        end else begin
            o_lat_vld <= wait_reg && i_vector_exec;
            if (wait_reg && i_vector_exec) begin
                o_lat <= cnt_reg;
                o_fast <= fast_reg;
                o_slow <= slow_reg | i_slow_cause;
            end
        end
    end
endmodule

//--- bench/bpt_testbench.sv
// self-checking bench for branch prediction and issue timing control
`timescale 1ns/1ns
module testbench;
    // ==========================================================
    // stimulus and observed signals
    logic i_mclk = 1'b0;
    logic i_rst;
    logic i_cand_vld, i_cand_dest_vld, i_cand_wb_vld, i_res_vld, i_res_cmp;
    logic i_res_taken, i_res_hit, i_res_pred_taken, i_irq;
    logic i_fast_interrupt_request;
    logic i_vector_exec, i_blk_load16, i_fault, i_load_wait, i_walk_busy;
    logic i_ratio_high, o_issue, o_pred_hit, o_pred_taken, o_mispredict;
    logic o_pen_busy, o_irq_lat_vld, o_irq_fast, o_irq_slow;
    logic [31:0] i_cand_pc, i_res_pc, i_res_target, o_pred_target;
    logic [31:0] o_redirect_target;
    logic [3:0] i_cand_dest, i_cand_wb, i_cand_res_lat, i_cand_rsrc_lat;
    logic [15:0] i_cand_src_mask, o_irq_lat;
    logic [4:0] cause;
    bpt_pkg::bpt_kind_e i_cand_kind, i_res_kind;
    int err_total = 0;
    int tests_run = 0;

    // delay causes as one vector, one bit each
    assign {i_blk_load16, i_fault, i_load_wait} = cause[4:2];
    assign {i_walk_busy, i_ratio_high} = cause[1:0];

    bpt_core_timing #(.BTB_ENTRIES(64), .BTB_IDX_W(6)) dut_u (.*);

    // free running 50 MHz clock
    always #10 i_mclk = ~i_mclk;

    // ==========================================================
    // compare and closing tasks
    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        tests_run++;
        if (g != e) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // drivers: candidate held until issue, edges counted to it
    task automatic issue(input logic [31:0] pc, input bpt_pkg::bpt_kind_e k,
        input logic [3:0] dst, input logic [3:0] wb, input logic [15:0] src,
        input logic [3:0] lat, output int n);
        @(negedge i_mclk);
        i_cand_vld = 1'b1;
        i_cand_pc = pc;
        i_cand_kind = k;
        i_cand_dest_vld = |dst;
        i_cand_dest = dst;
        i_cand_wb_vld = |wb;
        i_cand_wb = wb;
        i_cand_src_mask = src;
        i_cand_res_lat = lat;
        i_cand_rsrc_lat = lat;
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
        end while (o_issue !== 1'b1 && n < 20);
    endtask

    // resolve pulse with a plain candidate waiting behind it
    task automatic resolve(input logic [31:0] pc, input bpt_pkg::bpt_kind_e k,
        input logic c, input logic tk, input logic hit, input logic pt,
        input logic mis, input int gap);
        int n;
        logic [31:0] red;
        red = tk ? pc + 32'h0400 : pc + (c ? 32'h2 : 32'h4);
        @(negedge i_mclk);
        i_cand_vld = 1'b1;
        i_cand_pc = 32'h8000;
        i_cand_kind = bpt_pkg::KIND_OTHER;
        i_cand_dest_vld = 1'b0;
        i_cand_wb_vld = 1'b0;
        i_cand_src_mask = 16'h0000;
        i_res_vld = 1'b1;
        i_res_pc = pc;
        i_res_kind = k;
        i_res_cmp = c;
        i_res_taken = tk;
        i_res_target = pc + 32'h0400;
        i_res_hit = hit;
        i_res_pred_taken = pt;
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
            if (n == 1) begin
                chk_bit("mispredict", mis, o_mispredict);
                chk_bit("pen busy", mis, o_pen_busy);
                if (mis) chk_word("redirect", red, o_redirect_target);
                @(negedge i_mclk);
                i_res_vld = 1'b0;
            end
        end while (o_issue !== 1'b1 && n < 20);
        chk_cnt("issue gap", gap, n);
    endtask

    task automatic drop();
        @(negedge i_mclk);
        i_cand_vld = 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic btb_walk(input bpt_pkg::bpt_kind_e k,
        input logic [31:0] pc, input logic c);
        int n;
        int g;
        g = c ? 6 : 5;
        issue(pc, k, 4'h0, 4'h0, 16'h0000, 4'h1, n);
        chk_bit("cold hit", 1'b0, o_pred_hit);
        resolve(pc, k, c, 1'b1, 1'b0, 1'b0, 1'b1, g);
        issue(pc, k, 4'h0, 4'h0, 16'h0000, 4'h1, n);
        chk_bit("warm hit", 1'b1, o_pred_hit);
        chk_bit("warm taken", 1'b1, o_pred_taken);
        chk_word("warm target", pc + 32'h0400, o_pred_target);
        resolve(pc, k, c, 1'b1, 1'b1, 1'b1, 1'b0, 1);
        resolve(pc, k, c, 1'b0, 1'b1, 1'b1, 1'b1, g);
        resolve(pc, k, c, 1'b0, 1'b1, 1'b1, 1'b1, g);
        issue(pc, k, 4'h0, 4'h0, 16'h0000, 4'h1, n);
        chk_bit("weak hit", 1'b1, o_pred_hit);
        chk_bit("weak taken", 1'b0, o_pred_taken);
        resolve(pc, k, c, 1'b1, 1'b1, 1'b0, 1'b1, g);
        drop();
    endtask

    // request raised, vector run d cycles later, latency returned
    task automatic irq_meas(input logic f, input logic [4:0] c, input int d,
        output int lat);
        @(negedge i_mclk);
        i_irq = !f;
        i_fast_interrupt_request = f;
        cause = c;
        repeat (d) @(negedge i_mclk);
        i_vector_exec = 1'b1;
        @(posedge i_mclk);
        #1;
        chk_bit("lat valid", 1'b1, o_irq_lat_vld);
        chk_bit("fast", f, o_irq_fast);
        chk_bit("slow", |c, o_irq_slow);
        chk_bit("lat above sync", 1'b1, o_irq_lat > 16'h0002);
        lat = int'(o_irq_lat);
        @(negedge i_mclk);
        i_vector_exec = 1'b0;
        i_irq = 1'b0;
        i_fast_interrupt_request = 1'b0;
        cause = 5'h00;
        repeat (4) @(negedge i_mclk);
    endtask

    // ==========================================================
    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #40000;
        err_total++;
        $display("ERROR watchdog expected finish seen timeout");
        wrap_up();
    end

    // main sequence
    initial begin
        int n;
        int l1;
        int l2;
        i_rst = 1'b1;
        {i_cand_vld, i_cand_dest_vld, i_cand_wb_vld, i_res_vld, i_res_cmp,
            i_res_taken, i_res_hit, i_res_pred_taken, i_irq,
            i_fast_interrupt_request,
            i_vector_exec, cause, i_cand_pc, i_res_pc, i_res_target,
            i_cand_dest, i_cand_wb, i_cand_res_lat, i_cand_rsrc_lat,
            i_cand_src_mask} = '0;
        i_cand_kind = bpt_pkg::KIND_OTHER;
        i_res_kind = bpt_pkg::KIND_OTHER;
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst = 1'b0;
        @(posedge i_mclk);
        #1;
        chk_bit("issue at reset", 1'b0, o_issue);
        chk_bit("mis at reset", 1'b0, o_mispredict);
        chk_bit("busy at reset", 1'b0, o_pen_busy);
        issue(32'h10, bpt_pkg::KIND_OTHER, 4'h1, 4'h0, 16'h0000, 4'h3, n);
        issue(32'h14, bpt_pkg::KIND_OTHER, 4'h0, 4'h0, 16'h0002, 4'h1, n);
        chk_cnt("dep wait", 3, n);
        issue(32'h18, bpt_pkg::KIND_OTHER, 4'h5, 4'h0, 16'h0000, 4'h4, n);
        issue(32'h1C, bpt_pkg::KIND_OTHER, 4'h0, 4'h0, 16'h0001, 4'h1, n);
        chk_cnt("indep wait", 1, n);
        issue(32'h20, bpt_pkg::KIND_MUL, 4'h2, 4'h0, 16'h0000, 4'h2, n);
        issue(32'h24, bpt_pkg::KIND_MUL, 4'h0, 4'h0, 16'h0000, 4'h2, n);
        chk_cnt("mul wait", 2, n);
        issue(32'h28, bpt_pkg::KIND_OTHER, 4'h0, 4'h3, 16'h0000, 4'h1, n);
        issue(32'h2C, bpt_pkg::KIND_OTHER, 4'h0, 4'h0, 16'h0008, 4'h1, n);
        chk_cnt("wb wait", 1, n);
        drop();
        btb_walk(bpt_pkg::KIND_BR, 32'h1000, 1'b0);
        btb_walk(bpt_pkg::KIND_BR_LINK, 32'h2004, 1'b0);
        btb_walk(bpt_pkg::KIND_BR_CMP, 32'h3002, 1'b1);
        resolve(32'h4008, bpt_pkg::KIND_BR, 1'b0, 1'b0, 1'b0, 1'b0,
            1'b0, 1);
        issue(32'h4008, bpt_pkg::KIND_BR, 4'h0, 4'h0, 16'h0000, 4'h1, n);
        chk_bit("untaken hit", 1'b0, o_pred_hit);
        issue(32'h1000, bpt_pkg::KIND_PC_WRITE, 4'h0, 4'h0, 16'h0000,
            4'h1, n);
        chk_bit("pc write taken", 1'b0, o_pred_taken);
        resolve(32'h1000, bpt_pkg::KIND_PC_WRITE, 1'b0, 1'b1, 1'b0, 1'b0,
            1'b1, 5);
        resolve(32'h1000, bpt_pkg::KIND_PC_WRITE, 1'b0, 1'b0, 1'b0, 1'b0,
            1'b0, 1);
        drop();
        irq_meas(1'b0, 5'h00, 6, l1);
        irq_meas(1'b1, 5'h00, 10, l2);
        chk_cnt("lat step", 4, l2 - l1);
        for (int i = 0; i < 5; i++) begin
            irq_meas(1'b0, 5'h01 << i, 6, l1);
        end
        wrap_up();
    end
endmodule
